// ### src/dcc_top.sv
// Dual comparator control block: Avalon-MM register, flags, pad and mux control
//
// The implementer's own choices: the Avalon-MM register port and the address map.
`default_nettype none

module dcc_top (
  input  wire logic            CORE_CLK,
  input  wire logic            RESETN,
  input  wire logic [3:0]      AVS_ADDRESS,
  input  wire logic            AVS_READ,
  input  wire logic            AVS_WRITE,
  input  wire logic [31:0]     AVS_WRITEDATA,
  input  wire logic [3:0]      AVS_BYTEENABLE,
  output logic      [31:0]     AVS_READDATA,
  output logic                 AVS_WAITREQUEST,
  input  wire logic            IDLE_MODE,
  input  wire logic            CMP_A_RAW,
  input  wire logic            CMP_B_RAW,
  output logic                 CMP_A_POWER,
  output logic                 CMP_B_POWER,
  output dcc_pkg::dcc_mux_t    CMP_A_MUX,
  output dcc_pkg::dcc_mux_t    CMP_B_MUX,
  output logic                 CMP_A_PAD_OUT,
  output logic                 CMP_A_PAD_OE_N,
  output logic                 CMP_B_PAD_OUT,
  output logic                 CMP_B_PAD_OE_N,
  output logic                 CMP_IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Merge a bus write into the writable configuration under byte enables
  function automatic dcc_pkg::dcc_ctl_t ctl_merge(
    input dcc_pkg::dcc_ctl_t old,
    input logic [15:0]       d,
    input logic [1:0]        be
  );
    dcc_pkg::dcc_ctl_t n;
    n = old;
    if (be[1]) begin
      n.idle_stop = d[dcc_pkg::IDLE_STOP_BIT];
      n.b_on      = d[dcc_pkg::B_ON_BIT];
      n.a_on      = d[dcc_pkg::A_ON_BIT];
      n.b_pad     = d[dcc_pkg::B_PAD_BIT];
      n.a_pad     = d[dcc_pkg::A_PAD_BIT];
    end
    if (be[0]) begin
      n.b_inv   = d[dcc_pkg::B_INV_BIT];
      n.a_inv   = d[dcc_pkg::A_INV_BIT];
      n.b_minus = d[dcc_pkg::B_MINUS_BIT];
      n.b_plus  = d[dcc_pkg::B_PLUS_BIT];
      n.a_minus = d[dcc_pkg::A_MINUS_BIT];
      n.a_plus  = d[dcc_pkg::A_PLUS_BIT];
    end
    return n;
  endfunction

  // Software view of the control word; bit 14 reads zero
  function automatic logic [15:0] ctl_image(
    input dcc_pkg::dcc_ctl_t c,
    input logic              fb,
    input logic              fa,
    input logic              rb,
    input logic              ra
  );
    logic [15:0] w;
    w = dcc_pkg::CTRL_RESET;
    w[dcc_pkg::IDLE_STOP_BIT] = c.idle_stop;
    w[dcc_pkg::B_FLAG_BIT]    = fb;
    w[dcc_pkg::A_FLAG_BIT]    = fa;
    w[dcc_pkg::B_ON_BIT]      = c.b_on;
    w[dcc_pkg::A_ON_BIT]      = c.a_on;
    w[dcc_pkg::B_PAD_BIT]     = c.b_pad;
    w[dcc_pkg::A_PAD_BIT]     = c.a_pad;
    w[dcc_pkg::B_RESULT_BIT]  = rb;
    w[dcc_pkg::A_RESULT_BIT]  = ra;
    w[dcc_pkg::B_INV_BIT]     = c.b_inv;
    w[dcc_pkg::A_INV_BIT]     = c.a_inv;
    w[dcc_pkg::B_MINUS_BIT]   = c.b_minus;
    w[dcc_pkg::B_PLUS_BIT]    = c.b_plus;
    w[dcc_pkg::A_MINUS_BIT]   = c.a_minus;
    w[dcc_pkg::A_PLUS_BIT]    = c.a_plus;
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  dcc_pkg::dcc_ctl_t ctl_reg;
  dcc_pkg::dcc_ctl_t ctl_next;
  logic              ack_reg;
  logic [15:0]       rdata_reg;
  logic              a_flag_reg;
  logic              a_flag_next;
  logic              b_flag_reg;
  logic              b_flag_next;
  logic              a_oe_n_reg;
  logic              b_oe_n_reg;
  logic              irq_reg;
  logic              irq_next;
  logic              req;
  logic              hit;
  logic              wr_take;
  logic              a_clr;
  logic              b_clr;
  logic              a_result;
  logic              b_result;
  logic              a_change;
  logic              b_change;
  logic              irq_block;

  ////////////////////////////////////////////////////////////////////////////
  // Comparator channels

  dcc_cmp_chan u_chan_a (
    .clk    (CORE_CLK),
    .rst_n  (RESETN),
    .raw    (CMP_A_RAW),
    .on     (ctl_reg.a_on),
    .invert (ctl_reg.a_inv),
    .result (a_result),
    .change (a_change)
  );

  dcc_cmp_chan u_chan_b (
    .clk    (CORE_CLK),
    .rst_n  (RESETN),
    .raw    (CMP_B_RAW),
    .on     (ctl_reg.b_on),
    .invert (ctl_reg.b_inv),
    .result (b_result),
    .change (b_change)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then the answer

  assign req             = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack_reg;
  assign wr_take         = AVS_WRITE & ~AVS_WAITREQUEST & hit;

  always_comb begin
    if (AVS_ADDRESS == dcc_pkg::CTRL_OFFSET) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // Read data is captured one edge early so it stands at the accepting edge
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_reg <= dcc_pkg::CTRL_RESET;
    end else if (AVS_READ && !ack_reg) begin
      if (hit) begin
        rdata_reg <= ctl_image(ctl_reg, b_flag_reg, a_flag_reg, b_result, a_result);
      end else begin
        rdata_reg <= dcc_pkg::CTRL_RESET;
      end
    end
  end

  assign AVS_READDATA = {16'h0000, rdata_reg};

  ////////////////////////////////////////////////////////////////////////////
  // Configuration bits

  always_comb begin
    if (wr_take) begin
      ctl_next = ctl_merge(ctl_reg, AVS_WRITEDATA[15:0], AVS_BYTEENABLE[1:0]);
    end else begin
      ctl_next = ctl_reg;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctl_reg <= dcc_pkg::CTL_RESET;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // Idle only blocks the request; the comparators keep running
  assign CMP_A_POWER = ctl_reg.a_on;
  assign CMP_B_POWER = ctl_reg.b_on;

  // Plus side: pin or internal reference; minus side: minus pin or plus pin
  assign CMP_A_MUX.plus_from_pin   = ctl_reg.a_plus;
  assign CMP_A_MUX.minus_from_plus = ctl_reg.a_minus;
  assign CMP_B_MUX.plus_from_pin   = ctl_reg.b_plus;
  assign CMP_B_MUX.minus_from_plus = ctl_reg.b_minus;

  ////////////////////////////////////////////////////////////////////////////
  // Change flags: a hardware set beats a software clear in the same cycle

  assign a_clr = wr_take & AVS_BYTEENABLE[1] & ~AVS_WRITEDATA[dcc_pkg::A_FLAG_BIT];
  assign b_clr = wr_take & AVS_BYTEENABLE[1] & ~AVS_WRITEDATA[dcc_pkg::B_FLAG_BIT];

  always_comb begin
    a_flag_next = a_change | (a_flag_reg & ~a_clr);
    b_flag_next = b_change | (b_flag_reg & ~b_clr);
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      a_flag_reg <= 1'b0;
      b_flag_reg <= 1'b0;
    end else begin
      a_flag_reg <= a_flag_next;
      b_flag_reg <= b_flag_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pads; the pin mapping outside must be set up before drive is enabled

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      a_oe_n_reg <= 1'b1;
      b_oe_n_reg <= 1'b1;
    end else begin
      a_oe_n_reg <= ~(ctl_next.a_pad & ctl_next.a_on);
      b_oe_n_reg <= ~(ctl_next.b_pad & ctl_next.b_on);
    end
  end

  assign CMP_A_PAD_OUT  = a_result;
  assign CMP_B_PAD_OUT  = b_result;
  assign CMP_A_PAD_OE_N = a_oe_n_reg;
  assign CMP_B_PAD_OE_N = b_oe_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request

  assign irq_block = ctl_reg.idle_stop & IDLE_MODE;

  always_comb begin
    irq_next = (a_flag_reg | b_flag_reg) & ~irq_block;
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign CMP_IRQ = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_idle_blocks: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (ctl_reg.idle_stop && IDLE_MODE) |=> !CMP_IRQ) else $error("interrupt raised in idle stop");

  a_idle_keeps_on: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (IDLE_MODE && ctl_reg.a_on && !wr_take) |=> CMP_A_POWER) else $error("idle powered a comparator down");

  a_flag_sets: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (a_change || b_change) |=> (a_flag_reg || b_flag_reg)) else $error("change did not set a flag");

  a_flag_sticky: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (a_flag_reg && !a_clr) |=> a_flag_reg) else $error("flag dropped without a clear");

  a_flag_clear: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (b_clr && !b_change) |=> !b_flag_reg) else $error("flag clear ignored");

  a_irq_request: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    ((a_flag_reg || b_flag_reg) && !irq_block) |=> CMP_IRQ) else $error("flag did not request");

  a_pad_enable: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (ctl_reg.b_pad && ctl_reg.b_on) ##1 (ctl_reg.b_pad && ctl_reg.b_on) |-> !CMP_B_PAD_OE_N)
    else $error("pad not driven");

  a_pad_release: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    !ctl_reg.a_pad ##1 !ctl_reg.a_pad |-> CMP_A_PAD_OE_N) else $error("pad driven while disabled");

  a_minus_route: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (wr_take && AVS_BYTEENABLE[0]) |=>
    CMP_A_MUX.minus_from_plus == $past(AVS_WRITEDATA[dcc_pkg::A_MINUS_BIT])) else $error("minus route wrong");

  a_plus_route: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (wr_take && AVS_BYTEENABLE[0]) |=>
    CMP_B_MUX.plus_from_pin == $past(AVS_WRITEDATA[dcc_pkg::B_PLUS_BIT])) else $error("plus route wrong");

  a_bus_answer: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (req && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST) else $error("bus answer late");

endmodule

`default_nettype wire

// ### src/dcc_pkg.sv
// Constants, field positions and carrier types of the dual comparator control block
//
// How it works
// - With idle_stop set and the device in Idle, no interrupt request is raised, yet the comparators stay enabled.
// - Each comparator has a change flag (b at bit 13, a at bit 12) that is set when its output changes state.
// - A comparator works only while its on bit (b at bit 11, a at bit 10) is one; zero disables it.
// - A result drives its pad only while the pad drive bit (b at bit 9, a at bit 8) is one.
// - Result bits (b at bit 7, a at bit 6) read one when plus exceeds minus, reversed while inverted.
// - The invert bit (b at bit 5, a at bit 4) flips the result before status, change detection and pad.
// - The minus select bit (b at bit 3, a at bit 1) routes the plus pin to the minus input when one, else the minus pin.
// - The plus select bit (b at bit 2, a at bit 0) connects the plus pin when one, else the internal reference.
// - Inputs are chosen among the four dedicated pins and the shared internal reference level.
`default_nettype none

package dcc_pkg;

  localparam logic [3:0]  CTRL_OFFSET  = 4'h0;
  localparam logic [15:0] CTRL_RESET   = 16'h0000;

  localparam int IDLE_STOP_BIT = 15;
  localparam int B_FLAG_BIT    = 13;
  localparam int A_FLAG_BIT    = 12;
  localparam int B_ON_BIT      = 11;
  localparam int A_ON_BIT      = 10;
  localparam int B_PAD_BIT     = 9;
  localparam int A_PAD_BIT     = 8;
  localparam int B_RESULT_BIT  = 7;
  localparam int A_RESULT_BIT  = 6;
  localparam int B_INV_BIT     = 5;
  localparam int A_INV_BIT     = 4;
  localparam int B_MINUS_BIT   = 3;
  localparam int B_PLUS_BIT    = 2;
  localparam int A_MINUS_BIT   = 1;
  localparam int A_PLUS_BIT    = 0;

  // Analog input routing for one comparator
  typedef struct packed {
    logic plus_from_pin;
    logic minus_from_plus;
  } dcc_mux_t;

  // Software-writable configuration bits
  typedef struct packed {
    logic idle_stop;
    logic b_on;
    logic a_on;
    logic b_pad;
    logic a_pad;
    logic b_inv;
    logic a_inv;
    logic b_minus;
    logic b_plus;
    logic a_minus;
    logic a_plus;
  } dcc_ctl_t;

  localparam dcc_ctl_t CTL_RESET = 11'h000;

  // Bus answer latency: the slave answers on the second edge of a request
  localparam int BUS_WAIT_CYCLES = 1;

endpackage

`default_nettype wire

// ### src/dcc_cmp_chan.sv
// One comparator channel: synchroniser, inversion, enable gating and change detect
`default_nettype none

module dcc_cmp_chan (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic raw,
  input  wire logic on,
  input  wire logic invert,
  output logic      result,
  output logic      change
);

  logic sync1_reg;
  logic sync2_reg;
  logic result_reg;
  logic result_next;
  logic prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Raw decision is asynchronous, so it is only ever seen after two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= raw;
      sync2_reg <= sync1_reg;
    end
  end

  // A disabled comparator reports zero
  always_comb begin
    result_next = on ? (sync2_reg ^ invert) : 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_reg <= 1'b0;
    end else begin
      result_reg <= result_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= result_reg;
    end
  end

  // Toggling invert also counts as a change, since the flip happens before the detector
  assign change = on & (result_reg ^ prev_reg);
  assign result = result_reg;

  ////////////////////////////////////////////////////////////////////////////
  a_off_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !on |=> !result_reg) else $error("disabled comparator shows a result");

  a_off_no_change: assert property (@(posedge clk) disable iff (!rst_n)
    !on ##1 !on ##1 !on |-> !(result_reg ^ prev_reg)) else $error("disabled comparator flags a change");

  a_result_plain: assert property (@(posedge clk) disable iff (!rst_n)
    (on && !invert && raw) [*4] |-> result_reg) else $error("result does not follow raw");

  a_result_inv: assert property (@(posedge clk) disable iff (!rst_n)
    (on && invert && raw) [*4] |-> !result_reg) else $error("inverted result wrong");

  a_sync_depth: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(sync2_reg) |-> $past(raw, 2)) else $error("synchroniser depth wrong");

endmodule

`default_nettype wire

// ### dv/dcc_analog_model.sv
// Behavioural model of the two analog comparator cores and their input pins
`default_nettype none

module dcc_analog_model (
  input  wire logic              a_power,
  input  wire logic              b_power,
  input  wire dcc_pkg::dcc_mux_t a_mux,
  input  wire dcc_pkg::dcc_mux_t b_mux,
  input  wire logic [7:0]        a_plus_lvl,
  input  wire logic [7:0]        a_minus_lvl,
  input  wire logic [7:0]        b_plus_lvl,
  input  wire logic [7:0]        b_minus_lvl,
  input  wire logic [7:0]        ref_lvl,
  output logic                   a_raw,
  output logic                   b_raw
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic decide(input logic on, input dcc_pkg::dcc_mux_t m, input logic [7:0] p,
                                  input logic [7:0] n, input logic [7:0] r);
    logic [7:0] plus_v;
    logic [7:0] minus_v;
    plus_v  = m.plus_from_pin ? p : r;
    minus_v = m.minus_from_plus ? p : n;
    // Powered-down core idles low; equal inputs also read low
    return on && (plus_v > minus_v);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    a_raw = decide(a_power, a_mux, a_plus_lvl, a_minus_lvl, ref_lvl);
    b_raw = decide(b_power, b_mux, b_plus_lvl, b_minus_lvl, ref_lvl);
  end

endmodule

`default_nettype wire

// ### dv/dual_comparator_control_bench.sv
// Self-checking bench of the dual comparator control block
`default_nettype none

module dual_comparator_control_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk;
  logic              rst_n;
  logic              rd_en;
  logic              wr_en;
  logic              idle;
  logic [3:0]        addr;
  logic [3:0]        be;
  logic [31:0]       wdata;
  logic [31:0]       rdata;
  logic              waitreq;
  logic              a_raw;
  logic              b_raw;
  logic              a_pwr;
  logic              b_pwr;
  logic              a_pad;
  logic              b_pad;
  logic              a_oe_n;
  logic              b_oe_n;
  logic              irq;
  dcc_pkg::dcc_mux_t a_mux;
  dcc_pkg::dcc_mux_t b_mux;
  logic [7:0]        a_p;
  logic [7:0]        b_p;
  logic [7:0]        zero_lvl;
  logic [31:0]       q;
  logic [31:0]       res;
  logic [31:0]       flg;
  int                n_errors;
  int                check_count;

  dcc_top u_dut (
    .CORE_CLK(clk), .RESETN(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd_en), .AVS_WRITE(wr_en),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
    .IDLE_MODE(idle), .CMP_A_RAW(a_raw), .CMP_B_RAW(b_raw), .CMP_A_POWER(a_pwr), .CMP_B_POWER(b_pwr),
    .CMP_A_MUX(a_mux), .CMP_B_MUX(b_mux), .CMP_A_PAD_OUT(a_pad), .CMP_A_PAD_OE_N(a_oe_n),
    .CMP_B_PAD_OUT(b_pad), .CMP_B_PAD_OE_N(b_oe_n), .CMP_IRQ(irq)
  );

  // Minus pins and reference held at zero so a raised plus pin wins while plus takes the pin and minus takes the minus pin
  dcc_analog_model u_analog (
    .a_power(a_pwr), .b_power(b_pwr), .a_mux(a_mux), .b_mux(b_mux), .a_plus_lvl(a_p),
    .a_minus_lvl(zero_lvl), .b_plus_lvl(b_p), .b_minus_lvl(zero_lvl), .ref_lvl(zero_lvl),
    .a_raw(a_raw), .b_raw(b_raw)
  );

  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t ns %s: got %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // One Avalon access; idles one edge first so no signal is assigned twice in a step
  task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d, input logic [3:0] b);
    int n;
    @(posedge clk);
    n = 0;
    addr <= a;
    wr_en <= wr;
    rd_en <= ~wr;
    wdata <= {16'h0000, d};
    be <= b;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    if (n >= 20) begin
      n_errors++;
      finish_test();
    end
    q = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    rd_en = 1'b0;
    wr_en = 1'b0;
    idle = 1'b0;
    addr = 4'h0;
    be = 4'h0;
    wdata = 32'h00000000;
    a_p = 8'h00;
    b_p = 8'h00;
    zero_lvl = 8'h00;
    n_errors = 0;
    check_count = 0;
    res = 32'h00000000;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk(32'({a_pwr, b_pwr, a_mux, b_mux, a_oe_n, b_oe_n, irq}), 32'h00000006, "reset outputs");
    bus(1'b0, 4'h0, 16'h0000, 4'hF);
    chk(q, 32'h00000000, "reset value");
    bus(1'b1, 4'h0, 16'hFF0F, 4'hF);
    bus(1'b0, 4'h0, 16'h0000, 4'hF);
    chk(q, 32'h00008F0F, "read-only bits kept");
    chk(32'({a_pwr, b_pwr, a_mux, b_mux, a_oe_n, b_oe_n, irq}), 32'h000001F8, "config out");
    bus(1'b1, 4'h0, 16'h8F05, 4'hF);
    // The write lands at the accepting edge, so look one edge later
    @(posedge clk);
    chk(32'({a_mux, b_mux}), 32'h0000000A, "plus pin, minus pin");
    for (int ch = 0; ch < 2; ch++) begin
      res = res | (ch ? 32'h00000080 : 32'h00000040);
      flg = ch ? 32'h00002000 : 32'h00001000;
      if (ch) begin
        b_p <= 8'h80;
      end else begin
        a_p <= 8'h80;
      end
      repeat (8) @(posedge clk);
      bus(1'b0, 4'h0, 16'h0000, 4'hF);
      chk(q, 32'h00008F05 | res | flg, "change flag");
      chk(32'(ch ? b_pad : a_pad), 32'h00000001, "pad level");
      chk(32'(irq), 32'h00000001, "flag request");
      idle <= 1'b1;
      repeat (3) @(posedge clk);
      chk(32'(irq), 32'h00000000, "idle stop");
      idle <= 1'b0;
      bus(1'b1, 4'h0, 16'h8F05, 4'hF);
      repeat (3) @(posedge clk);
      chk(32'(irq), 32'h00000000, "flag clear");
      bus(1'b0, 4'h0, 16'h0000, 4'hF);
      chk(q, 32'h00008F05 | res, "flag cleared");
    end
    // Low lane only: high byte must survive, inverting a high result raises an event
    bus(1'b1, 4'h0, 16'h0015, 4'h1);
    repeat (8) @(posedge clk);
    bus(1'b0, 4'h0, 16'h0000, 4'hF);
    chk(q, 32'h00009F95, "invert event");
    chk(32'({a_pad, b_pad}), 32'h00000001, "inverted pad");
    bus(1'b1, 4'h4, 16'h0000, 4'hF);
    bus(1'b0, 4'h4, 16'h0000, 4'hF);
    chk(q, 32'h00000000, "unmapped read");
    bus(1'b0, 4'h0, 16'h0000, 4'hF);
    chk(q, 32'h00009F95, "unmapped write");
    bus(1'b1, 4'h0, 16'h0335, 4'hF);
    repeat (8) @(posedge clk);
    bus(1'b0, 4'h0, 16'h0000, 4'hF);
    chk(q, 32'h00000335, "comparators off");
    chk(32'({a_pwr, b_pwr, a_oe_n, b_oe_n, irq}), 32'h00000006, "off outputs");
    finish_test();
  end

endmodule

`default_nettype wire
